// ### wake_filter_pkg.sv
package wake_filter_pkg;

   // =====================================================================
   // register offsets
   localparam logic [7:0] OFS_TARGET_ID_LOW = 8'h33;
   localparam logic [7:0] OFS_EXT_MASK_TOP = 8'h34;
   localparam logic [7:0] OFS_EXT_MASK_MID = 8'h35;
   localparam logic [7:0] OFS_EXT_MASK_LOW = 8'h36;
   localparam logic [7:0] OFS_BASE_MASK_HIGH = 8'h37;
   localparam logic [7:0] OFS_BASE_MASK_LEN = 8'h38;
   localparam logic [7:0] OFS_EXPECTED_FIRST = 8'h39;
   localparam logic [7:0] OFS_EXPECTED_LAST = 8'h40;
   localparam logic [7:0] OFS_SPARE_FIRST = 8'h41;
   localparam logic [7:0] OFS_SPARE_LAST = 8'h43;
   localparam logic [7:0] OFS_BUS_RATE = 8'h44;

   // =====================================================================
   // field positions
   localparam int TID_HI = 7;
   localparam int TID_LO = 2;
   localparam int MASK_TOP_HI = 1;
   localparam int BMASK_HI = 7;
   localparam int BMASK_LO = 5;
   localparam int LEN_HI = 4;
   localparam int LEN_LO = 1;
   localparam int DATA_EN_BIT = 0;
   localparam int FD_IGNORE_BIT = 7;
   localparam int RATE_HI = 6;
   localparam int RATE_LO = 4;
   localparam int RATIO_HI = 3;
   localparam int RATIO_LO = 2;

   // =====================================================================
   // values after reset, and error counter limit
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_BUS_RATE = 8'h50;
   localparam logic [2:0] RST_RATE = 3'h5;
   localparam logic [1:0] RST_RATIO = 2'h0;
   localparam logic [7:0] ERR_CNT_MAX = 8'hFF;

   // =====================================================================
   // nominal rate and fast phase ratio codes
   typedef enum logic [2:0] {
      RATE_50K = 3'b000,
      RATE_100K = 3'b001,
      RATE_125K = 3'b010,
      RATE_250K = 3'b011,
      RATE_RSVD_A = 3'b100,
      RATE_500K = 3'b101,
      RATE_RSVD_B = 3'b110,
      RATE_1M = 3'b111
   } rate_e;

   typedef enum logic [1:0] {
      RATIO_UPTO_4X = 2'b00,
      RATIO_5X_10X = 2'b01,
      RATIO_RSVD_A = 2'b10,
      RATIO_RSVD_B = 2'b11
   } ratio_e;

   localparam int EXP_BYTES = 8;

endpackage

// ### wake_frame_matcher.sv
`timescale 1ns/1ps
// combinational comparison of one received frame against the stored filter
module wake_frame_matcher
   import wake_filter_pkg::*;
(
   // stored target and masks
   input wire logic id_format_ext,
   input wire logic [28:0] target_id,
   input wire logic [28:0] id_mask,
   input wire logic [3:0] expect_len,
   input wire logic [63:0] expect_data,
   // received frame
   input wire logic frame_ide,
   input wire logic [28:0] frame_id,
   input wire logic [3:0] frame_dlc,
   input wire logic [63:0] frame_data,
   // results
   output logic id_ok,
   output logic len_ok,
   output logic data_ok
);

   // =====================================================================
   // every bit set in the expected byte must also be set in the received one
   function automatic logic byte_covers(input logic [7:0] rx, input logic [7:0] want);
      return (rx & want) == want;
   endfunction

   logic [3:0] present;
   logic [28:0] diff;

   always_comb
   begin
      diff = '0;
      // base frames compare only the low eleven bits, the rest is ignored
      if (id_format_ext)
      begin
         diff = (frame_id ^ target_id) & ~id_mask;
      end
      else
      begin
         diff[10:0] = (frame_id[10:0] ^ target_id[10:0]) & ~id_mask[10:0];
      end
      id_ok = (frame_ide == id_format_ext) && (diff == '0);
      len_ok = (frame_dlc == expect_len);
      // a classic frame carries at most eight bytes whatever the length code says
      present = (frame_dlc > 4'h8) ? 4'h8 : frame_dlc;
      data_ok = 1'b1;
      for (int i = 0; i < EXP_BYTES; i++)
      begin
         if (4'(i) < present && !byte_covers(frame_data[8*i +: 8], expect_data[8*i +: 8]))
         begin
            data_ok = 1'b0;
         end
      end
   end

endmodule // wake_frame_matcher

// ### wake_frame_filter.sv
`timescale 1ns/1ps
// Contract
// - 33h bits 7:2 hold low target id bits; bits 1:0 read zero
// - 34h bits 1:0 hold extended mask 17:16; upper bits read zero
// - 35h holds extended mask 15:8, read-write, resets to zero
// - 36h holds extended mask 7:0, read-write, resets to zero
// - 37h holds base mask 10:3, also extended mask 28:21
// - 38h bits 7:5 hold base mask 2:0, also extended mask 20:18
// - data match on: length code must equal 38h bits 4:1; remote frames ignored
// - data match on: every set expected bit within the received length, up to eight bytes, must be set in received data
// - data match off: length and data assumed valid, remote frames allowed
// - fd ignore clear: every received fd frame counts as error
// - fd ignore set: fd frames are passed over without counting
// - 44h bits 6:4 select nominal rate; 100b and 110b reserved
// - 44h bits 3:2 select fd ratio; 10b and 11b reserved
// - 44h resets to 50h; bits 1:0 read-only zero
// - format bit selects 11-bit base or 29-bit extended target
// - error counter plus one per frame error, minus one per good frame
// - with fd ignore set, fd frames leave the counter unchanged
module wake_frame_filter
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access from the serial port core
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // target id parts held outside this block
   input wire logic id_format_ext,
   input wire logic [4:0] target_id_top,
   input wire logic [17:0] target_ext_low,
   // received frame summary from the protocol decoder
   input wire logic frame_done,
   input wire logic frame_err,
   input wire logic frame_ide,
   input wire logic frame_rtr,
   input wire logic frame_fdf,
   input wire logic [28:0] frame_id,
   input wire logic [3:0] frame_dlc,
   input wire logic [63:0] frame_data,
   // results and configuration for the rest of the device
   output logic wake_event,
   output logic [7:0] frame_error_count,
   output wake_filter_pkg::rate_e nominal_rate_select,
   output wake_filter_pkg::ratio_e fast_phase_ratio_select,
   output logic fd_frame_ignore,
   output logic cfg_code_reserved
);
   import wake_filter_pkg::*;

   typedef struct packed {
      logic [5:0] target_id_low_bits;
      logic [1:0] ext_mask_bits_top;
      logic [7:0] ext_mask_bits_mid;
      logic [7:0] ext_mask_bits_low;
      logic [7:0] base_mask_high_bits;
      logic [2:0] base_mask_low_bits;
      logic [3:0] expect_len;
      logic data_match_en;
      logic [7:0][7:0] expected_payload_byte;
      logic fd_ignore;
      rate_e rate;
      ratio_e ratio;
      logic [7:0] err_cnt;
      logic [7:0] rdata;
      logic rvalid;
      logic wake;
      logic code_rsvd;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   // =====================================================================
   // address decode, shared by the read and write paths
   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic rate_reserved(input logic [2:0] r, input logic [1:0] q);
      return (r == RATE_RSVD_A) || (r == RATE_RSVD_B) || (q == RATIO_RSVD_A) ||
             (q == RATIO_RSVD_B);
   endfunction

   // =====================================================================
   // filter fields assembled from the stored registers
   logic [28:0] target_id;
   logic [28:0] id_mask;
   logic id_ok;
   logic len_ok;
   logic data_ok;
   logic [2:0] exp_idx;

   // base id {top5, low6}; extended id keeps the same top eleven bits
   assign target_id = id_format_ext ?
      {target_id_top, state_r.target_id_low_bits, target_ext_low} :
      {18'h00000, target_id_top, state_r.target_id_low_bits};
   assign id_mask = id_format_ext ?
      {state_r.base_mask_high_bits, state_r.base_mask_low_bits, state_r.ext_mask_bits_top,
       state_r.ext_mask_bits_mid, state_r.ext_mask_bits_low} :
      {18'h00000, state_r.base_mask_high_bits, state_r.base_mask_low_bits};
   assign exp_idx = 3'(reg_addr - OFS_EXPECTED_FIRST);

   wake_frame_matcher u_match (
      .id_format_ext(id_format_ext),
      .target_id(target_id),
      .id_mask(id_mask),
      .expect_len(state_r.expect_len),
      .expect_data(state_r.expected_payload_byte),
      .frame_ide(frame_ide),
      .frame_id(frame_id),
      .frame_dlc(frame_dlc),
      .frame_data(frame_data),
      .id_ok(id_ok),
      .len_ok(len_ok),
      .data_ok(data_ok)
   );

   // =====================================================================
   // frame classification
   logic fd_skip;
   logic count_up;
   logic count_down;
   logic qualifies;

   always_comb
   begin
      fd_skip = frame_fdf && state_r.fd_ignore;
      // a fd frame is an error frame unless it is passed over
      count_up = !fd_skip && (frame_err || (frame_done && frame_fdf));
      count_down = frame_done && !frame_err && !frame_fdf;
      qualifies = frame_done && !frame_err && !frame_fdf && id_ok;
      if (state_r.data_match_en)
      begin
         qualifies = qualifies && !frame_rtr && len_ok && data_ok;
      end
   end

   // =====================================================================
   // next state
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.rvalid = 1'b0;
      state_nxt.wake = qualifies;
      // counter saturates at both ends so a long error burst cannot wrap to zero
      if (count_up && state_r.err_cnt != ERR_CNT_MAX)
      begin
         state_nxt.err_cnt = state_r.err_cnt + 8'h01;
      end
      else if (count_down && state_r.err_cnt != 8'h00)
      begin
         state_nxt.err_cnt = state_r.err_cnt - 8'h01;
      end
      if (reg_wr)
      begin
         case (reg_addr)
            OFS_TARGET_ID_LOW: state_nxt.target_id_low_bits = reg_wdata[TID_HI:TID_LO];
            OFS_EXT_MASK_TOP: state_nxt.ext_mask_bits_top = reg_wdata[MASK_TOP_HI:0];
            OFS_EXT_MASK_MID: state_nxt.ext_mask_bits_mid = reg_wdata;
            OFS_EXT_MASK_LOW: state_nxt.ext_mask_bits_low = reg_wdata;
            OFS_BASE_MASK_HIGH: state_nxt.base_mask_high_bits = reg_wdata;
            OFS_BASE_MASK_LEN:
            begin
               state_nxt.base_mask_low_bits = reg_wdata[BMASK_HI:BMASK_LO];
               state_nxt.expect_len = reg_wdata[LEN_HI:LEN_LO];
               state_nxt.data_match_en = reg_wdata[DATA_EN_BIT];
            end
            OFS_BUS_RATE:
            begin
               state_nxt.fd_ignore = reg_wdata[FD_IGNORE_BIT];
               // reserved codes are stored as written and flagged to the rate logic
               state_nxt.rate = rate_e'(reg_wdata[RATE_HI:RATE_LO]);
               state_nxt.ratio = ratio_e'(reg_wdata[RATIO_HI:RATIO_LO]);
            end
            default:
            begin
               if (in_range(reg_addr, OFS_EXPECTED_FIRST, OFS_EXPECTED_LAST))
               begin
                  state_nxt.expected_payload_byte[exp_idx] = reg_wdata;
               end
            end
         endcase
      end
      state_nxt.code_rsvd = rate_reserved(state_nxt.rate, state_nxt.ratio);
      if (reg_rd)
      begin
         state_nxt.rvalid = 1'b1;
         case (reg_addr)
            OFS_TARGET_ID_LOW: state_nxt.rdata = {state_r.target_id_low_bits, 2'b00};
            OFS_EXT_MASK_TOP: state_nxt.rdata = {6'h00, state_r.ext_mask_bits_top};
            OFS_EXT_MASK_MID: state_nxt.rdata = state_r.ext_mask_bits_mid;
            OFS_EXT_MASK_LOW: state_nxt.rdata = state_r.ext_mask_bits_low;
            OFS_BASE_MASK_HIGH: state_nxt.rdata = state_r.base_mask_high_bits;
            OFS_BASE_MASK_LEN: state_nxt.rdata = {state_r.base_mask_low_bits,
                                                  state_r.expect_len, state_r.data_match_en};
            OFS_BUS_RATE: state_nxt.rdata = {state_r.fd_ignore, state_r.rate,
                                             state_r.ratio, 2'b00};
            default:
            begin
               // spare locations and unmapped addresses both answer zero
               state_nxt.rdata = RST_BYTE;
               if (in_range(reg_addr, OFS_EXPECTED_FIRST, OFS_EXPECTED_LAST))
               begin
                  state_nxt.rdata = state_r.expected_payload_byte[exp_idx];
               end
            end
         endcase
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= '0;
         state_r.rate <= rate_e'(RST_BUS_RATE[RATE_HI:RATE_LO]);
         state_r.ratio <= ratio_e'(RST_BUS_RATE[RATIO_HI:RATIO_LO]);
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata = state_r.rdata;
   assign reg_rvalid = state_r.rvalid;
   assign wake_event = state_r.wake;
   assign frame_error_count = state_r.err_cnt;
   assign nominal_rate_select = state_r.rate;
   assign fast_phase_ratio_select = state_r.ratio;
   assign fd_frame_ignore = state_r.fd_ignore;
   assign cfg_code_reserved = state_r.code_rsvd;

   // =====================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_cnt_up: assert property (
      frame_err && !frame_fdf && frame_error_count != ERR_CNT_MAX
      |=> frame_error_count == $past(frame_error_count) + 8'h01)
      else $error("error count did not rise on frame error");

   chk_cnt_down: assert property (
      frame_done && !frame_err && !frame_fdf && frame_error_count != 8'h00
      |=> frame_error_count == $past(frame_error_count) - 8'h01)
      else $error("error count did not fall on good frame");

   chk_fd_passive: assert property (
      fd_frame_ignore && frame_fdf && (frame_done || frame_err)
      |=> $stable(frame_error_count))
      else $error("fd frame changed count while passed over");

   chk_fd_counted: assert property (
      !fd_frame_ignore && frame_fdf && frame_done && frame_error_count == 8'h00
      |=> frame_error_count == 8'h01)
      else $error("fd frame not counted as error");

   chk_wake_id: assert property (
      wake_event |-> $past(id_ok) && $past(frame_done) && !$past(frame_fdf))
      else $error("wake without matching id");

   chk_remote_block: assert property (
      frame_done && frame_rtr && state_r.data_match_en |=> !wake_event)
      else $error("remote frame woke with data match on");

   chk_len_gate: assert property (
      wake_event && $past(state_r.data_match_en)
      |-> $past(frame_dlc) == $past(state_r.expect_len) && $past(data_ok))
      else $error("wake with length or data mismatch");

   chk_no_data_match: assert property (
      frame_done && !frame_err && !frame_fdf && id_ok && !state_r.data_match_en
      |=> wake_event)
      else $error("id match alone did not wake");

   chk_spare_zero: assert property (
      reg_rd && in_range(reg_addr, OFS_SPARE_FIRST, OFS_SPARE_LAST)
      |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("spare location read non-zero");

   chk_low_bits_zero: assert property (
      reg_rd && (reg_addr == OFS_TARGET_ID_LOW || reg_addr == OFS_BUS_RATE)
      |=> reg_rdata[1:0] == 2'b00)
      else $error("reserved low bits read non-zero");

   chk_rate_reset: assert property (
      $past(rst) |-> nominal_rate_select == RST_RATE && fast_phase_ratio_select == RST_RATIO
      && !fd_frame_ignore)
      else $error("bus rate register not at reset value");

   cov_wake_data: cover property (wake_event && state_r.data_match_en);
   cov_wake_plain: cover property (wake_event && !state_r.data_match_en);
   cov_fd_skip: cover property (frame_done && frame_fdf && fd_frame_ignore);
   cov_cnt_down: cover property (frame_error_count == 8'h01 ##1 frame_error_count == 8'h00);

endmodule // wake_frame_filter

// ### wake_frame_source.sv
`timescale 1ns/1ps
// =====================================================================
// far-side node: hands one frame summary at a time to the filter
module wake_frame_source
(
   // clock
   input wire logic clk,
   // frame summary
   output logic frame_done,
   output logic frame_err,
   output logic frame_ide,
   output logic frame_rtr,
   output logic frame_fdf,
   output logic [28:0] frame_id,
   output logic [3:0] frame_dlc,
   output logic [63:0] frame_data
);
   initial
   begin
      frame_done = 1'b0;
      frame_err = 1'b0;
      frame_ide = 1'b0;
      frame_rtr = 1'b0;
      frame_fdf = 1'b0;
      frame_id = 29'h0;
      frame_dlc = 4'h0;
      frame_data = 64'h0;
   end

   task automatic send(input logic ok, input logic bad, input logic ide, input logic rtr,
                       input logic fdf, input logic [28:0] id, input logic [3:0] dlc,
                       input logic [63:0] d);
      @(posedge clk);
      frame_done <= ok;
      frame_err <= bad;
      frame_ide <= ide;
      frame_rtr <= rtr;
      frame_fdf <= fdf;
      frame_id <= id;
      frame_dlc <= dlc;
      frame_data <= d;
      @(posedge clk);
      frame_done <= 1'b0;
      frame_err <= 1'b0;
      // fields are only valid with the strobe, so they must not linger afterwards
      frame_ide <= ~ide;
      frame_rtr <= ~rtr;
      frame_fdf <= ~fdf;
      frame_id <= ~id;
      frame_dlc <= ~dlc;
      frame_data <= ~d;
   endtask
endmodule // wake_frame_source

// ### selective_wake_frame_filter_tb.sv
`timescale 1ns/1ps
module selective_wake_frame_filter_tb;
   import wake_filter_pkg::*;
   logic clk, rst, reg_wr, reg_rd, reg_rvalid, ext, wake_event, fd_ign, cfg_rsvd;
   logic f_done, f_err, f_ide, f_rtr, f_fdf;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, err_cnt;
   logic [4:0] top;
   logic [17:0] ext_low;
   logic [28:0] f_id;
   logic [3:0] f_dlc;
   logic [63:0] f_data;
   rate_e rate_out;
   ratio_e ratio_out;
   logic [7:0] mdl [0:255];
   logic [31:0] seed = 32'h0000_0B3D;
   int err_total = 0;
   int checks_done = 0;
   int cnt = 0;

   wake_frame_filter dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .id_format_ext(ext), .target_id_top(top), .target_ext_low(ext_low),
      .frame_done(f_done), .frame_err(f_err), .frame_ide(f_ide), .frame_rtr(f_rtr),
      .frame_fdf(f_fdf), .frame_id(f_id), .frame_dlc(f_dlc), .frame_data(f_data),
      .wake_event(wake_event), .frame_error_count(err_cnt), .nominal_rate_select(rate_out),
      .fast_phase_ratio_select(ratio_out), .fd_frame_ignore(fd_ign),
      .cfg_code_reserved(cfg_rsvd));
   wake_frame_source src_u (.clk(clk), .frame_done(f_done), .frame_err(f_err),
      .frame_ide(f_ide), .frame_rtr(f_rtr), .frame_fdf(f_fdf), .frame_id(f_id),
      .frame_dlc(f_dlc), .frame_data(f_data));

   // =====================================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // writable bits of each address; everything else reads zero
   function automatic logic [7:0] wmask(input logic [7:0] a);
      if (a == OFS_TARGET_ID_LOW || a == OFS_BUS_RATE) return 8'hFC;
      if (a == OFS_EXT_MASK_TOP) return 8'h03;
      if (a >= OFS_EXT_MASK_MID && a <= OFS_EXPECTED_LAST) return 8'hFF;
      return 8'h00;
   endfunction

   function automatic logic exp_wake(input logic ide, input logic rtr, input logic fdf,
                                     input logic [28:0] id, input logic [3:0] dlc,
                                     input logic [63:0] d);
      logic [28:0] tgt;
      logic [28:0] msk;
      logic ok;
      int n;
      if (ext)
      begin
         tgt = {top, mdl[8'h33][7:2], ext_low};
         msk = {mdl[8'h37], mdl[8'h38][7:5], mdl[8'h34][1:0], mdl[8'h35], mdl[8'h36]};
      end
      else
      begin
         tgt = {18'h0, top, mdl[8'h33][7:2]};
         msk = {18'h3FFFF, mdl[8'h37], mdl[8'h38][7:5]};
      end
      ok = (ide === ext) && (((id ^ tgt) & ~msk) == 29'h0) && !fdf;
      if (mdl[8'h38][0])
      begin
         ok = ok && !rtr && (dlc == mdl[8'h38][4:1]);
         n = (dlc > 8) ? 8 : int'(dlc);
         for (int y = 0; y < n; y++)
            if ((d[8*y +: 8] & mdl[8'h39 + y]) != mdl[8'h39 + y]) ok = 1'b0;
      end
      return ok;
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h0, got}, {7'h0, exp});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      mdl[a] = d & wmask(a);
   endtask

   task automatic rd_chk(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check_bit(reg_rvalid, 1'b1);
      check_byte(reg_rdata, mdl[a]);
   endtask

   task automatic sweep(input int mode);
      for (int a = 8'h30; a <= 8'h47; a++)
         if (mode == 1) wr(a[7:0], 8'hFF);
         else if (mode == 2) wr(a[7:0], 8'(rnd()));
         else rd_chk(a[7:0]);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // =====================================================================
   // clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      test_done();
   end

   initial
   begin
      logic [31:0] r;
      logic [28:0] id;
      logic [63:0] d;
      logic [3:0] dlc;
      logic bad, ide, rtr, fdf, w;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      ext = 1'b0;
      top = 5'h00;
      ext_low = 18'h0;
      for (int a = 0; a < 256; a++) mdl[a] = 8'h00;
      mdl[OFS_BUS_RATE] = RST_BUS_RATE;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      sweep(0);
      sweep(1);
      sweep(0);
      sweep(2);
      sweep(0);
      for (int c = 0; c < 64; c++)
      begin
         wr(OFS_BUS_RATE, {c[5], c[2:0], c[4:3], 2'b11});
         @(posedge clk);
         #1;
         check_byte({5'h0, rate_out}, {5'h0, c[2:0]});
         check_byte({6'h0, ratio_out}, {6'h0, c[4:3]});
         check_bit(fd_ign, c[5]);
         check_bit(cfg_rsvd, c[2:0] == 3'h4 || c[2:0] == 3'h6 || c[4]);
      end
      for (int i = 0; i < 700; i++)
      begin
         if (i % 50 == 0)
         begin
            r = rnd();
            @(posedge clk);
            ext <= r[0];
            top <= r[5:1];
            ext_low <= r[31:14];
            for (int a = 8'h33; a <= 8'h40; a++) wr(a[7:0], 8'(rnd()));
            wr(OFS_BUS_RATE, {r[6], 3'h5, 4'h0});
         end
         r = rnd();
         id = ext ? {top, mdl[8'h33][7:2], ext_low} : {18'h0, top, mdl[8'h33][7:2]};
         id = r[3] ? id ^ (29'(rnd()) & (r[9] ? 29'h1FFF_FFFF : 29'h3)) : 29'(rnd());
         if (!ext) id[28:11] = 18'h0;
         d = {rnd(), rnd()};
         for (int y = 0; y < 8; y++) if (r[4]) d[8*y +: 8] |= mdl[8'h39 + y];
         dlc = r[5] ? mdl[8'h38][4:1] : r[11:8];
         ide = (r[7:6] == 2'b00) ? ~ext : ext;
         rtr = r[12] & r[13];
         fdf = r[14] & r[15];
         bad = (r[18:16] >= 3'h6);
         src_u.send(r[18:16] != 3'h7, bad, ide, rtr, fdf, id, dlc, d);
         #1;
         w = !bad && exp_wake(ide, rtr, fdf, id, dlc, d);
         if (bad || fdf)
         begin
            if (!(fdf && mdl[OFS_BUS_RATE][7]) && cnt < 255) cnt++;
         end
         else if (cnt > 0)
            cnt--;
         check_bit(wake_event, w);
         check_byte(err_cnt, cnt[7:0]);
      end
      test_done();
   end
endmodule // selective_wake_frame_filter_tb
